//--- req_cpl_map.vh
// Constants of the requester completion stream block.
`ifndef REQ_CPL_MAP_VH
`define REQ_CPL_MAP_VH

`define DATA_W 512
`define LANES 16
`define DESC_W 96
`define DESC_DWS 5'h03
`define ALIGN_BASE_DWS 5'h04
`define SB_W 97
`define SB_SOP_BIT 64
`define SOP_FLAGS_W 4
`define BE_W 64
`define DWCNT_LSB 32
`define DWCNT_MSB 42
`define CNT_W 11
`define RST_DATA 512'h0
`define RST_KEEP 16'h0000
`define RST_SB 97'h0

`endif

//--- requester_completion_stream.v
// Requester completion stream source: completion header and payload in, packet out.
`timescale 1ns/1ps
`default_nettype none
`include "req_cpl_map.vh"

module requester_completion_stream (
	// Clock and reset.
	input wire ref_clk,
	input wire resetn,
	// Mode: high selects 128-bit address-aligned delivery.
	input wire addr_aligned_mode,
	// Completion header from the link side.
	input wire cpl_in_valid,
	output reg cpl_in_ready,
	input wire [`DESC_W-1:0] cpl_in_desc,
	input wire [`CNT_W-1:0] cpl_in_payload_dws,
	input wire cpl_in_zero_len,
	input wire [3:0] cpl_in_first_be,
	input wire [3:0] cpl_in_last_be,
	input wire [1:0] cpl_in_addr_offset,
	// Payload beats from the link side, Dword 0 of the payload in lane 0.
	input wire pay_in_valid,
	output reg pay_in_ready,
	input wire [`DATA_W-1:0] pay_in_data,
	// Completion stream toward user logic.
	output reg [`DATA_W-1:0] cpl_stream_payload_bus,
	output reg cpl_stream_valid,
	input wire cpl_stream_ready,
	output reg [`LANES-1:0] cpl_stream_dword_keep,
	output reg cpl_stream_last,
	output reg [`SB_W-1:0] cpl_stream_sideband
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_FIRST = 2'b01;
	localparam [1:0] ST_MID = 2'b10;
	localparam [1:0] ST_FLUSH = 2'b11;

	// Shifts a beat up by a number of Dwords.
	function [`DATA_W-1:0] shl_dw;
		input [`DATA_W-1:0] d;
		input [4:0] n;
		begin
			shl_dw = d << {n, 5'h00};
		end
	endfunction

	// Keeps the top n Dwords of a beat, moved down to lane zero.
	function [`DATA_W-1:0] top_dw;
		input [`DATA_W-1:0] d;
		input [4:0] n;
		begin
			top_dw = d >> {5'h10 - n, 5'h00};
		end
	endfunction

	// Byte enables of one Dword lane from its position in the packet.
	function [3:0] dword_be;
		input [`CNT_W-1:0] pos;
		input [4:0] s;
		input [`CNT_W-1:0] n;
		input [3:0] fbe;
		input [3:0] lbe;
		input zl;
		reg [`CNT_W-1:0] p;
		begin
			p = pos - {6'h00, s};
			if (zl || pos < {6'h00, s} || p >= n)
				dword_be = 4'h0;
			else if (p == 11'h000)
				dword_be = fbe;
			else if (p == n - 11'h001)
				dword_be = lbe;
			else
				dword_be = 4'hf;
		end
	endfunction

	reg [1:0] state_r, state_nxt;
	reg [`DESC_W-1:0] desc_r;
	reg [`CNT_W-1:0] n_r;
	reg zl_r;
	reg [3:0] fbe_r, lbe_r;
	reg [4:0] shift_r;
	reg [`CNT_W-1:0] in_left_r, in_left_nxt;
	reg [`CNT_W-1:0] out_left_r, out_left_nxt;
	reg [`CNT_W-1:0] base_r, base_nxt;
	reg [`DATA_W-1:0] carry_r, carry_nxt;
	reg skid_valid_r;
	reg [`DATA_W-1:0] skid_data_r;
	reg [`LANES-1:0] skid_keep_r;
	reg skid_last_r;
	reg [`SB_W-1:0] skid_sb_r;

	reg emit;
	reg take_pay;
	reg [`DATA_W-1:0] beat_data;
	reg [`LANES-1:0] beat_keep;
	reg beat_last;
	reg [`SB_W-1:0] beat_sb;
	reg [`CNT_W-1:0] beat_cnt;
	reg [`DESC_W-1:0] desc_out;
	reg skid_valid_nxt;
	integer i;

	wire out_load = !cpl_stream_valid || cpl_stream_ready;
	wire hdr_take = (state_r == ST_IDLE) && cpl_in_valid && cpl_in_ready;
	wire pay_fire = pay_in_valid && pay_in_ready;
	wire [`CNT_W-1:0] n_eff = cpl_in_zero_len ? 11'h001 : cpl_in_payload_dws;

	// Beat builder: decides whether a beat is produced and forms it.
	always @* begin
		emit = 1'b0;
		take_pay = 1'b0;
		state_nxt = state_r;
		in_left_nxt = in_left_r;
		out_left_nxt = out_left_r;
		base_nxt = base_r;
		carry_nxt = carry_r;
		beat_data = `RST_DATA;
		// Without straddling only the first start flag is ever used.
		beat_sb = `RST_SB;
		desc_out = desc_r;
		if (zl_r)
			desc_out[`DWCNT_MSB:`DWCNT_LSB] = 11'h001;
		beat_cnt = (out_left_r > 11'h010) ? 11'h010 : out_left_r;
		// Contiguous keep from lane zero, short only in the last beat.
		beat_keep = ~(16'hffff << beat_cnt[4:0]);
		if (beat_cnt == 11'h010)
			beat_keep = 16'hffff;
		beat_last = (out_left_r <= 11'h010);
		case (state_r)
			ST_IDLE: begin
				if (hdr_take)
					state_nxt = ST_FIRST;
			end
			ST_FIRST: begin
				if (n_r == 11'h000) begin
					// Descriptor only, one beat.
					emit = !skid_valid_r;
					beat_data = {416'h0, desc_out};
					if (emit)
						state_nxt = ST_IDLE;
				end else begin
					emit = pay_fire;
					take_pay = pay_fire;
					// Payload right behind the descriptor or at its
					// aligned lane in the same beat.
					beat_data = shl_dw(pay_in_data, shift_r) |
						{416'h0, desc_out};
				end
				beat_sb[`SB_SOP_BIT] = 1'b1;
			end
			ST_MID: begin
				emit = pay_fire;
				take_pay = pay_fire;
				beat_data = shl_dw(pay_in_data, shift_r) | carry_r;
			end
			ST_FLUSH: begin
				// Dwords spilled from the last link beat go out alone.
				emit = !skid_valid_r;
				beat_data = carry_r;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// Byte enables per lane, only on payload Dwords. Lanes past the
		// keep carry zero data, so unused link lanes never leak out.
		for (i = 0; i < `LANES; i = i + 1) begin
			beat_sb[i*4 +: 4] = beat_keep[i] ? dword_be(base_r +
				i[`CNT_W-1:0], shift_r, n_r, fbe_r, lbe_r,
				zl_r) : 4'h0;
			if (!beat_keep[i])
				beat_data[i*32 +: 32] = 32'h0;
		end
		// A produced beat moves the lane base and the Dword counters on.
		if (emit) begin
			base_nxt = base_r + 11'h010;
			out_left_nxt = out_left_r - beat_cnt;
			if (take_pay) begin
				carry_nxt = top_dw(pay_in_data, shift_r);
				in_left_nxt = (in_left_r > 11'h010) ?
					in_left_r - 11'h010 : 11'h000;
			end
			if (state_r != ST_FIRST || n_r != 11'h000) begin
				if (beat_last)
					state_nxt = ST_IDLE;
				else if (take_pay && in_left_nxt == 11'h000)
					state_nxt = ST_FLUSH;
				else
					state_nxt = ST_MID;
			end
		end
		// The output skid fills only when a beat is made while stalled.
		skid_valid_nxt = skid_valid_r;
		if (out_load)
			skid_valid_nxt = 1'b0;
		else if (emit)
			skid_valid_nxt = 1'b1;
	end

	// Header capture and packet counters.
	always @(posedge ref_clk) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			desc_r <= 96'h0;
			n_r <= 11'h000;
			zl_r <= 1'b0;
			fbe_r <= 4'h0;
			lbe_r <= 4'h0;
			shift_r <= `DESC_DWS;
			in_left_r <= 11'h000;
			out_left_r <= 11'h000;
			base_r <= 11'h000;
			carry_r <= `RST_DATA;
		end else begin
			state_r <= state_nxt;
			in_left_r <= in_left_nxt;
			out_left_r <= out_left_nxt;
			base_r <= base_nxt;
			carry_r <= carry_nxt;
			// A taken header fixes the shift, lengths and enables.
			if (hdr_take) begin
				desc_r <= cpl_in_desc;
				n_r <= n_eff;
				zl_r <= cpl_in_zero_len;
				fbe_r <= cpl_in_first_be;
				lbe_r <= cpl_in_last_be;
				in_left_r <= n_eff;
				base_r <= 11'h000;
				carry_r <= `RST_DATA;
				if (n_eff == 11'h000) begin
					shift_r <= `DESC_DWS;
					out_left_r <= {6'h00, `DESC_DWS};
				end else if (addr_aligned_mode) begin
					// Lanes 4 to 7, set by the request offset.
					shift_r <= `ALIGN_BASE_DWS +
						{3'h0, cpl_in_addr_offset};
					out_left_r <= n_eff + {6'h00, `ALIGN_BASE_DWS} +
						{9'h000, cpl_in_addr_offset};
				end else begin
					shift_r <= `DESC_DWS;
					out_left_r <= n_eff + {6'h00, `DESC_DWS};
				end
			end
		end
	end

	// Input readies come from flops and look at the next state. The header
	// ready stays low from a take until the packet's last beat is made,
	// and payload ready drops while the skid holds a beat.
	always @(posedge ref_clk) begin
		if (!resetn) begin
			cpl_in_ready <= 1'b0;
			pay_in_ready <= 1'b0;
		end else begin
			cpl_in_ready <= (state_nxt == ST_IDLE) && !hdr_take;
			pay_in_ready <= !skid_valid_nxt &&
				((state_nxt == ST_FIRST && (hdr_take ? n_eff :
				n_r) != 11'h000) || state_nxt == ST_MID);
		end
	end

	// Output stage and skid: a stalled beat is held unchanged.
	always @(posedge ref_clk) begin
		if (!resetn) begin
			cpl_stream_valid <= 1'b0;
			cpl_stream_payload_bus <= `RST_DATA;
			cpl_stream_dword_keep <= `RST_KEEP;
			cpl_stream_last <= 1'b0;
			cpl_stream_sideband <= `RST_SB;
			skid_valid_r <= 1'b0;
			skid_data_r <= `RST_DATA;
			skid_keep_r <= `RST_KEEP;
			skid_last_r <= 1'b0;
			skid_sb_r <= `RST_SB;
		end else begin
			skid_valid_r <= skid_valid_nxt;
			if (out_load) begin
				// Beats follow back to back while the link feeds.
				cpl_stream_valid <= skid_valid_r || emit;
				if (skid_valid_r) begin
					cpl_stream_payload_bus <= skid_data_r;
					cpl_stream_dword_keep <= skid_keep_r;
					cpl_stream_last <= skid_last_r;
					cpl_stream_sideband <= skid_sb_r;
				end else if (emit) begin
					cpl_stream_payload_bus <= beat_data;
					cpl_stream_dword_keep <= beat_keep;
					cpl_stream_last <= beat_last;
					cpl_stream_sideband <= beat_sb;
				end
			end else if (emit) begin
				// Sink stalled: park the new beat.
				skid_data_r <= beat_data;
				skid_keep_r <= beat_keep;
				skid_last_r <= beat_last;
				skid_sb_r <= beat_sb;
			end
		end
	end

endmodule // requester_completion_stream
`default_nettype wire

//--- req_cpl_properties.sv
// Checker of the completion stream outputs, bound to the block.
`timescale 1ns/1ps
`default_nettype none
`include "req_cpl_map.vh"
module req_cpl_properties (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Completion stream.
	input wire logic [`DATA_W-1:0] cpl_stream_payload_bus,
	input wire logic cpl_stream_valid,
	input wire logic cpl_stream_ready,
	input wire logic [`LANES-1:0] cpl_stream_dword_keep,
	input wire logic cpl_stream_last,
	input wire logic [`SB_W-1:0] cpl_stream_sideband
);
	logic in_pkt_r;
	logic [63:0] keep_bytes;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Tracks whether a packet has begun and not yet ended.
	always @(posedge ref_clk) begin
		if (!resetn)
			in_pkt_r <= 1'b0;
		else if (cpl_stream_valid && cpl_stream_ready)
			in_pkt_r <= !cpl_stream_last;
	end
	// Widens the Dword keep to one bit per byte lane.
	always_comb begin
		for (int i = 0; i < 16; i++)
			keep_bytes[4*i +: 4] = {4{cpl_stream_dword_keep[i]}};
	end
	property p_hold;
		cpl_stream_valid && !cpl_stream_ready |=> cpl_stream_valid &&
		$stable(cpl_stream_payload_bus) && $stable(cpl_stream_dword_keep) &&
		$stable(cpl_stream_last) && $stable(cpl_stream_sideband);
	endproperty
	a_hold: assert property (p_hold) else $error("beat changed in stall");
	property p_no_gap;
		cpl_stream_valid && !cpl_stream_last |=> cpl_stream_valid;
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("valid gap");
	property p_keep_full;
		cpl_stream_valid && !cpl_stream_last |-> cpl_stream_dword_keep == 16'hffff;
	endproperty
	a_keep_full: assert property (p_keep_full) else $error("short keep");
	property p_keep_contig;
		cpl_stream_valid |-> cpl_stream_dword_keep[0] && ((cpl_stream_dword_keep
		& (cpl_stream_dword_keep + 16'h0001)) == 16'h0000);
	endproperty
	a_keep_contig: assert property (p_keep_contig) else $error("keep gap");
	property p_sop_first;
		cpl_stream_valid |-> cpl_stream_sideband[64] == !in_pkt_r;
	endproperty
	a_sop_first: assert property (p_sop_first) else $error("start flag");
	property p_nopay_one;
		cpl_stream_valid && cpl_stream_sideband[64] &&
		cpl_stream_dword_keep == 16'h0007 |-> cpl_stream_last;
	endproperty
	a_nopay_one: assert property (p_nopay_one) else $error("no last");
	property p_be_in_keep;
		cpl_stream_valid |-> (cpl_stream_sideband[63:0] & ~keep_bytes) == 64'h0;
	endproperty
	a_be_in_keep: assert property (p_be_in_keep) else $error("be lane");
	property p_be_desc;
		cpl_stream_valid && cpl_stream_sideband[64] |->
		cpl_stream_sideband[11:0] == 12'h000;
	endproperty
	a_be_desc: assert property (p_be_desc) else $error("be desc");
	property p_sb_quiet;
		cpl_stream_valid |-> cpl_stream_sideband[96:65] == 32'h0;
	endproperty
	a_sb_quiet: assert property (p_sb_quiet) else $error("sideband");
	property p_no_straddle;
		cpl_stream_valid |-> cpl_stream_sideband[67:65] == 3'h0;
	endproperty
	a_no_straddle: assert property (p_no_straddle)
		else $error("straddle flag");
endmodule // req_cpl_properties
bind requester_completion_stream req_cpl_properties u_props (.ref_clk,
	.resetn, .cpl_stream_payload_bus, .cpl_stream_valid, .cpl_stream_ready,
	.cpl_stream_dword_keep, .cpl_stream_last, .cpl_stream_sideband);
`default_nettype wire

//--- cpl_sink_model.sv
// User-side sink model that accepts completion beats, promptly or slowly.
`timescale 1ns/1ps
`default_nettype none
module cpl_sink_model (
	// Clock and stall control.
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic coin,
	// Stream handshake.
	output logic cpl_stream_ready
);
	// In slow mode ready drops on random beats; otherwise it stays high.
	always @(negedge ref_clk) begin
		cpl_stream_ready <= !slow || coin;
	end
endmodule // cpl_sink_model
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench of the requester completion stream.
`timescale 1ns/1ps
`default_nettype none
`include "req_cpl_map.vh"
module tb_top;
	localparam int BW = `DATA_W + `LANES + 1 + `SB_W;
	logic ref_clk, resetn, mode, hv, pv, zl, slow, coin;
	logic [`DESC_W-1:0] desc;
	logic [`CNT_W-1:0] ndw;
	logic [3:0] fbe, lbe;
	logic [1:0] off;
	logic [`DATA_W-1:0] pdat;
	wire hr, pr, sv, sr, sl;
	wire [`DATA_W-1:0] sd;
	wire [`LANES-1:0] sk;
	wire [`SB_W-1:0] ssb;
	logic [BW-1:0] expq[$];
	logic [31:0] seed, r, pay[0:63], dw[0:79];
	logic [3:0] be[0:79];
	int num_errors, num_checks, cyc;
	requester_completion_stream dut (.ref_clk(ref_clk), .resetn(resetn),
		.addr_aligned_mode(mode), .cpl_in_valid(hv), .cpl_in_ready(hr),
		.cpl_in_desc(desc), .cpl_in_payload_dws(ndw), .cpl_in_zero_len(zl),
		.cpl_in_first_be(fbe), .cpl_in_last_be(lbe), .cpl_in_addr_offset(off),
		.pay_in_valid(pv), .pay_in_ready(pr), .pay_in_data(pdat),
		.cpl_stream_payload_bus(sd), .cpl_stream_valid(sv),
		.cpl_stream_ready(sr), .cpl_stream_dword_keep(sk),
		.cpl_stream_last(sl), .cpl_stream_sideband(ssb));
	cpl_sink_model sink (.ref_clk(ref_clk), .slow(slow), .coin(coin),
		.cpl_stream_ready(sr));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmp(input logic [BW-1:0] got, input logic [BW-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Sends one completion, never straddled, and notes its expected beats.
	task automatic send(input int n, input logic z, input logic am,
		input logic [1:0] o);
		int s, t, nb, k, j;
		logic [`DATA_W-1:0] ed;
		logic [15:0] ek;
		logic [`SB_W-1:0] es;
		nb = z ? 1 : n;
		// A completion without payload keeps its three descriptor Dwords only.
		s = (am && nb > 0) ? 4 + o : 3;
		t = s + nb;
		@(negedge ref_clk);
		r = xs();
		mode = am;
		zl = z;
		off = o;
		ndw = n[10:0];
		fbe = r[3:0];
		lbe = r[7:4];
		desc = {xs(), xs(), xs()};
		for (k = 0; k < 80; k++) begin
			dw[k] = 32'h0;
			be[k] = 4'h0;
		end
		dw[0] = desc[31:0];
		dw[1] = desc[63:32];
		dw[2] = desc[95:64];
		if (z)
			dw[1][10:0] = 11'h001;
		for (k = 0; k < nb; k++) begin
			pay[k] = xs();
			dw[s+k] = pay[k];
			be[s+k] = (k == 0) ? fbe : (k == nb - 1) ? lbe : 4'hf;
		end
		if (z)
			be[s] = 4'h0;
		for (int b = 0; b * 16 < t; b++) begin
			ed = '0;
			ek = '0;
			es = '0;
			for (j = 0; j < 16 && b * 16 + j < t; j++) begin
				ed[32*j +: 32] = dw[b*16+j];
				ek[j] = 1'b1;
				es[4*j +: 4] = be[b*16+j];
			end
			es[64] = (b == 0);
			expq.push_back({ed, ek, b * 16 + 16 >= t, es});
		end
		hv = 1'b1;
		while (!hr)
			@(negedge ref_clk);
		@(negedge ref_clk);
		hv = 1'b0;
		for (k = 0; k < nb; k += 16) begin
			for (j = 0; j < 16; j++)
				pdat[32*j +: 32] = (k + j < nb) ? pay[k+j] : ~pay[0];
			pv = 1'b1;
			while (!pr)
				@(negedge ref_clk);
			@(negedge ref_clk);
		end
		pv = 1'b0;
	endtask
	// Free-running clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Random stall coin and the run's cycle ceiling.
	always @(negedge ref_clk) begin
		coin <= ^xs();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// Every accepted beat is checked against the oldest note.
	always @(posedge ref_clk) begin
		if (resetn && sv && sr) begin
			if (expq.size() == 0) begin
				num_errors++;
				$display("mismatch at %0t got %h expected %h", $time, sd, 0);
			end else
				cmp({sd, sk, sl, ssb}, expq.pop_front());
		end
	end
	// Reset, directed lengths and offsets, then random traffic with stalls.
	initial begin
		seed = 32'h0000be3d;
		{num_errors, num_checks, cyc} = '0;
		{resetn, mode, hv, pv, zl, slow, coin} = '0;
		{desc, ndw, fbe, lbe, off, pdat} = '0;
		repeat (16) @(negedge ref_clk);
		resetn = 1'b1;
		foreach (pay[i])
			if (i < 8)
				send(i == 0 ? 0 : i < 3 ? i : i * 9 - 18, 1'b0, 1'b0, 2'h0);
		send(5, 1'b1, 1'b0, 2'h0);
		for (int i = 0; i < 4; i++)
			send(13 + i, 1'b0, 1'b1, i[1:0]);
		slow = 1'b1;
		for (int i = 0; i < 14; i++) begin
			r = xs();
			send(int'(r % 32'd48), r[8], r[9], r[11:10]);
		end
		while (expq.size() != 0)
			@(negedge ref_clk);
		repeat (4) @(negedge ref_clk);
		conclude();
	end
endmodule // tb_top
`default_nettype wire
